// ### core/estat_top.sv
// ethernet mac statistics, transmit retry sequencing and link status over apb
`timescale 1ns/10ps
// What this block does
// - count received frames longer than 1518 bytes
// - count received frames with bad crc
// - count frames whose bit length misaligned
// - count receive fifo overflow losses
// - count frames missed for lack of buffer
// - count filtered frames only while bridging enabled
// - reading filtered count clears it
// - receive collision, missed survive statistics clear
// - count long frames lacking second buffer
// - count frames sent after exactly one retry
// - count first-attempt collision then success
// - count frames with several collisions, then success
// - abandon after sixteen collisions and count
// - truncate on transmit fifo empty, count underflow
// - carrier loss flagged, no retry, frame completes
// - collision after slot time: late, counted, no retry
// - count frames needing two or more retries
// - total collisions adds every collision of frame
// - count deferrals, including dma busy
// - flag excessive deferral per ieee rules
// - report speed and duplex, unknown without link
// - warn when partner skipped negotiation
module estat_top
	import estat_pkg::*;
#(
	parameter logic [16:0] EXDEF_CYC_10M  = 17'(EXDEF_BITS * BIT_NS_10M / CLK_NS),
	parameter logic [16:0] EXDEF_CYC_100M = 17'(EXDEF_BITS * BIT_NS_100M / CLK_NS)
)(
	input  wire logic                CLK_SYS,
	input  wire logic                RSTN,
	// apb slave
	input  wire logic                PSEL,
	input  wire logic                PENABLE,
	input  wire logic                PWRITE,
	input  wire logic [ESTAT_AW-1:0] PADDR,
	input  wire logic [31:0]         PWDATA,
	output logic      [31:0]         PRDATA,
	output logic                     PREADY,
	output logic                     PSLVERR,
	// receive events from the mac, same clock
	input  wire logic                RX_END,
	input  wire logic [15:0]         RX_LEN_BYTES,
	input  wire logic                RX_CRC_ERR,
	input  wire logic                RX_ODD_BITS,
	input  wire logic                RX_FILTER_DROP,
	input  wire logic                RX_FIFO_OVF,
	input  wire logic                RX_NO_BUF,
	input  wire logic                RX_NO_BUF2,
	input  wire logic                RX_COLL,
	// transmit handshake with the mac, same clock
	input  wire logic                TX_REQ,
	input  wire logic                TX_BACKOFF,
	input  wire logic                TX_DMA_BUSY,
	input  wire logic                TX_COLL,
	input  wire logic                TX_FIFO_EMPTY,
	input  wire logic                TX_LAST,
	output logic                     TX_GO,
	output logic                     TX_RETRY,
	output logic                     TX_ABANDON,
	output logic                     TX_TRUNC,
	output logic                     TX_DONE,
	// pins from the phy
	input  wire logic                TX_CRS,
	input  wire logic                LINK_UP,
	input  wire logic                LINK_SPD100,
	input  wire logic                LINK_FDX,
	input  wire logic                PARTNER_AN,
	// link status
	output logic      [1:0]          SPEED_CODE,
	output logic      [1:0]          DUPLEX_CODE,
	output logic                     DUPLEX_WARN
);
	// ======================================================
	// pin synchronisers
	logic [4:0] pins_s;
	logic       crs_s;
	logic       link_s;
	logic       spd100_s;
	logic       fdx_s;
	logic       pan_s;

	estat_sync #(.N(5)) u_sync (
		.clk  (CLK_SYS),
		.rstn (RSTN),
		.din  ({PARTNER_AN, LINK_FDX, LINK_SPD100, LINK_UP, TX_CRS}),
		.dout (pins_s)
	);

	assign crs_s    = pins_s[0];
	assign link_s   = pins_s[1];
	assign spd100_s = pins_s[2];
	assign fdx_s    = pins_s[3];
	assign pan_s    = pins_s[4];

	// ======================================================
	// apb register access
	logic [31:0]     ctrl_q;
	logic            clr_stats_q;
	logic            reinit_q;
	logic [31:0]     rdata_q;
	logic [31:0]     rdata_d;
	logic [5:0]      idx;
	logic            hit;
	logic            setup_rd;
	logic            access_wr;
	logic            bridge_en;
	estat_tx_t       st_q;
	logic [1:0]      spd_q;
	logic [1:0]      dpx_q;
	logic            warn_q;
	logic [ESTAT_CNT_W-1:0] cnt_v [ESTAT_NCNT];

	assign idx       = PADDR[7:2];
	assign hit       = (PADDR[1:0] == 2'h0) &&
	                   ((idx < 6'(ESTAT_NCNT)) || PADDR == OFF_CTRL || PADDR == OFF_STAT);
	assign setup_rd  = PSEL && !PENABLE && !PWRITE;
	assign access_wr = PSEL && PENABLE && PWRITE && PADDR == OFF_CTRL;
	assign bridge_en = ctrl_q[CTRL_BRIDGE];
	// zero wait states; read data is taken at setup so no access needs stalling
	assign PREADY    = 1'b1;
	assign PSLVERR   = PSEL && PENABLE && !hit;
	assign PRDATA    = rdata_q;

	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (!hit)
			rdata_d = 32'h0000_0000;
		else if (PADDR == OFF_CTRL)
			rdata_d = {29'h0000_0000, 2'h0, bridge_en};
		else if (PADDR == OFF_STAT)
		begin
			rdata_d[STAT_SPEED_LSB +: 2]  = spd_q;
			rdata_d[STAT_DUPLEX_LSB +: 2] = dpx_q;
			rdata_d[STAT_WARN]            = warn_q;
			rdata_d[STAT_LINK]            = link_s;
			rdata_d[STAT_TXST_LSB +: 2]   = st_q;
		end
		else
			rdata_d = 32'(cnt_v[idx[4:0]]);
	end

	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			rdata_q <= 32'h0000_0000;
		else if (setup_rd)
			rdata_q <= rdata_d;
	end

	// clear bits are self-clearing strobes, only bridge enable is stored
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ctrl_q      <= CTRL_RESET;
			clr_stats_q <= 1'b0;
			reinit_q    <= 1'b0;
		end
		else
		begin
			clr_stats_q <= access_wr && PWDATA[CTRL_CLR_STATS];
			reinit_q    <= access_wr && PWDATA[CTRL_REINIT];
			if (access_wr)
				ctrl_q <= {31'h0000_0000, PWDATA[CTRL_BRIDGE]};
		end
	end

	// ======================================================
	// link status
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			spd_q  <= SPD_UNKNOWN;
			dpx_q  <= DPX_UNKNOWN;
			warn_q <= 1'b0;
		end
		else
		begin
			spd_q  <= !link_s ? SPD_UNKNOWN : (spd100_s ? SPD_100M : SPD_10M);
			dpx_q  <= !link_s ? DPX_UNKNOWN : (fdx_s ? DPX_FULL : DPX_HALF);
			warn_q <= link_s && !pan_s;
		end
	end

	assign SPEED_CODE  = spd_q;
	assign DUPLEX_CODE = dpx_q;
	assign DUPLEX_WARN = warn_q;

	// ======================================================
	// transmit sequencer
	logic [TMR_W-1:0] tmr_q;
	logic [4:0]       coll_q;
	logic             loc_q;
	logic             exdef_q;
	logic             busy;
	logic             in_send;
	logic             coll_evt;
	logic             late;
	logic             excess;
	logic             retry;
	logic             trunc;
	logic             done;
	logic             good;
	logic             frame_end;
	logic             defer_evt;
	logic             exdef_evt;
	logic [16:0]      slot_lim;
	logic [16:0]      exdef_lim;

	// carrier only defers in half duplex; full duplex waits on dma alone
	assign busy      = TX_DMA_BUSY || (crs_s && !fdx_s);
	assign in_send   = st_q == TX_SEND;
	assign slot_lim  = spd100_s ? SLOT_CYC_100M : SLOT_CYC_10M;
	assign exdef_lim = spd100_s ? EXDEF_CYC_100M : EXDEF_CYC_10M;
	assign coll_evt  = in_send && TX_COLL;
	assign late      = coll_evt && tmr_q >= slot_lim;
	assign excess    = coll_evt && !late && coll_q == COLL_LIMIT - 5'h01;
	assign retry     = coll_evt && !late && !excess && !loc_q;
	assign trunc     = in_send && !coll_evt && TX_FIFO_EMPTY && !TX_LAST;
	assign done      = in_send && !coll_evt && TX_LAST;
	assign good      = done && !loc_q;
	assign frame_end = done || trunc || (coll_evt && !retry);
	// each entry to defer while the medium or dma is busy is one deferral
	assign defer_evt = st_q == TX_DEFER && tmr_q == '0 && busy && !TX_BACKOFF;
	assign exdef_evt = st_q == TX_DEFER && busy && !exdef_q && tmr_q == exdef_lim;

	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			st_q   <= TX_IDLE;
			tmr_q  <= '0;
			coll_q <= 5'h00;
		end
		else if (reinit_q)
		begin
			st_q   <= TX_IDLE;
			tmr_q  <= '0;
			coll_q <= 5'h00;
		end
		else
		begin
			if (tmr_q != '1)
				tmr_q <= tmr_q + 17'h0_0001;
			case (st_q)
			TX_IDLE:
			begin
				coll_q <= 5'h00;
				tmr_q  <= '0;
				if (TX_REQ)
					st_q <= TX_DEFER;
			end
			TX_DEFER:
			begin
				if (TX_BACKOFF)
					tmr_q <= '0;
				else if (!busy)
				begin
					st_q  <= TX_SEND;
					tmr_q <= '0;
				end
			end
			TX_SEND:
			begin
				if (retry)
				begin
					coll_q <= coll_q + 5'h01;
					st_q   <= TX_DEFER;
					tmr_q  <= '0;
				end
				else if (frame_end)
					st_q <= TX_IDLE;
			end
			default:
				st_q <= TX_IDLE;
			endcase
		end
	end

	// carrier loss and excessive deferral are remembered for the frame
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			loc_q   <= 1'b0;
			exdef_q <= 1'b0;
		end
		else if (st_q == TX_IDLE)
		begin
			loc_q   <= 1'b0;
			exdef_q <= 1'b0;
		end
		else
		begin
			if (in_send && !crs_s && !fdx_s)
				loc_q <= 1'b1;
			if (exdef_evt)
				exdef_q <= 1'b1;
		end
	end

	// strobes to the mac, registered
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			TX_GO      <= 1'b0;
			TX_RETRY   <= 1'b0;
			TX_ABANDON <= 1'b0;
			TX_TRUNC   <= 1'b0;
			TX_DONE    <= 1'b0;
		end
		else
		begin
			TX_GO      <= st_q == TX_DEFER && !TX_BACKOFF && !busy && !reinit_q;
			TX_RETRY   <= retry;
			TX_ABANDON <= coll_evt && !retry;
			TX_TRUNC   <= trunc;
			TX_DONE    <= done;
		end
	end

	// ======================================================
	// counter bank
	logic [ESTAT_INC_W-1:0] inc_a [ESTAT_NCNT];
	logic [ESTAT_NCNT-1:0]  clr_a;
	logic                   rd_filtered;

	assign rd_filtered = setup_rd && PADDR == 8'(CI_FILTERED * 4);

	always_comb
	begin
		for (int i = 0; i < ESTAT_NCNT; i++)
		begin
			inc_a[i] = 5'h00;
			// statistics clear spares the adapter-held counters
			clr_a[i] = reinit_q || (clr_stats_q && i != CI_RX_COLL && i != CI_MISSED);
		end
		clr_a[CI_FILTERED]     = clr_a[CI_FILTERED] || rd_filtered;
		inc_a[CI_TOO_LONG]     = 5'(RX_END && RX_LEN_BYTES > MAX_FRAME_BYTES);
		inc_a[CI_CRC]          = 5'(RX_END && RX_CRC_ERR);
		inc_a[CI_ALIGN]        = 5'(RX_END && RX_ODD_BITS);
		inc_a[CI_RX_OVF]       = 5'(RX_FIFO_OVF);
		inc_a[CI_RX_COLL]      = 5'(RX_COLL);
		inc_a[CI_MISSED]       = 5'(RX_NO_BUF);
		inc_a[CI_FILTERED]     = 5'(RX_END && RX_FILTER_DROP && bridge_en);
		inc_a[CI_RX_UNDERRUN]  = 5'(RX_NO_BUF2);
		inc_a[CI_ONE_RETRY]    = 5'(good && coll_q == 5'h01);
		inc_a[CI_SINGLE_COLL]  = 5'(good && coll_q == 5'h01);
		inc_a[CI_MULTI_COLL]   = 5'(good && coll_q > 5'h01);
		inc_a[CI_TX_UNDERFLOW] = 5'(trunc);
		inc_a[CI_EXCESS_COLL]  = 5'(excess);
		inc_a[CI_LOST_CARRIER] = 5'(frame_end && loc_q);
		inc_a[CI_LATE_COLL]    = 5'(late);
		inc_a[CI_MULTI_RETRY]  = 5'(good && coll_q > 5'h01);
		inc_a[CI_TOTAL_COLL]   = frame_end ? coll_q + 5'(coll_evt) : 5'h00;
		inc_a[CI_EXCESS_DEFER] = 5'(exdef_evt);
		inc_a[CI_DEFERRED]     = 5'(defer_evt);
	end

	for (genvar g = 0; g < ESTAT_NCNT; g++)
	begin : g_cnt
		estat_cnt u_cnt (
			.clk  (CLK_SYS),
			.rstn (RSTN),
			.clr  (clr_a[g]),
			.inc  (inc_a[g]),
			.val  (cnt_v[g])
		);
	end
endmodule : estat_top

// ### core/estat_pkg.sv
// shared constants, register map and types of the ethernet statistics block
package estat_pkg;
	// ======================================================
	// counters
	localparam int          ESTAT_CNT_W     = 16;
	localparam int          ESTAT_NCNT      = 19;
	localparam int          ESTAT_INC_W     = 5;
	localparam int          CI_TOO_LONG     = 0;
	localparam int          CI_CRC          = 1;
	localparam int          CI_ALIGN        = 2;
	localparam int          CI_RX_OVF       = 3;
	localparam int          CI_RX_COLL      = 4;
	localparam int          CI_MISSED       = 5;
	localparam int          CI_FILTERED     = 6;
	localparam int          CI_RX_UNDERRUN  = 7;
	localparam int          CI_ONE_RETRY    = 8;
	localparam int          CI_SINGLE_COLL  = 9;
	localparam int          CI_MULTI_COLL   = 10;
	localparam int          CI_TX_UNDERFLOW = 11;
	localparam int          CI_EXCESS_COLL  = 12;
	localparam int          CI_LOST_CARRIER = 13;
	localparam int          CI_LATE_COLL    = 14;
	localparam int          CI_MULTI_RETRY  = 15;
	localparam int          CI_TOTAL_COLL   = 16;
	localparam int          CI_EXCESS_DEFER = 17;
	localparam int          CI_DEFERRED     = 18;
	// ======================================================
	// register map, byte offsets; counter n sits at 4*n
	localparam int          ESTAT_AW        = 8;
	localparam logic [7:0]  OFF_CTRL        = 8'h50;
	localparam logic [7:0]  OFF_STAT        = 8'h54;
	localparam int          CTRL_BRIDGE     = 0;
	localparam int          CTRL_CLR_STATS  = 1;
	localparam int          CTRL_REINIT     = 2;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
	localparam int          STAT_SPEED_LSB  = 0;
	localparam int          STAT_DUPLEX_LSB = 2;
	localparam int          STAT_WARN       = 4;
	localparam int          STAT_LINK       = 5;
	localparam int          STAT_TXST_LSB   = 8;
	// ======================================================
	// status codes
	localparam logic [1:0]  SPD_UNKNOWN     = 2'h0;
	localparam logic [1:0]  SPD_10M         = 2'h1;
	localparam logic [1:0]  SPD_100M        = 2'h2;
	localparam logic [1:0]  DPX_UNKNOWN     = 2'h0;
	localparam logic [1:0]  DPX_HALF        = 2'h1;
	localparam logic [1:0]  DPX_FULL        = 2'h2;
	// ======================================================
	// frame and timing figures
	localparam logic [15:0] MAX_FRAME_BYTES = 16'h05EE;
	localparam logic [4:0]  COLL_LIMIT      = 5'h10;
	localparam int          CLK_NS          = 40;
	localparam int          BIT_NS_10M      = 100;
	localparam int          BIT_NS_100M     = 10;
	localparam int          SLOT_BITS       = 512;
	localparam int          EXDEF_BITS      = 24288;
	localparam int          TMR_W           = 17;
	localparam logic [16:0] SLOT_CYC_10M    = 17'(SLOT_BITS * BIT_NS_10M / CLK_NS);
	localparam logic [16:0] SLOT_CYC_100M   = 17'(SLOT_BITS * BIT_NS_100M / CLK_NS);
	// ======================================================
	// transmit sequencer, gray along idle, defer, send
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_DEFER = 2'b01,
		TX_SEND  = 2'b11
	} estat_tx_t;
endpackage : estat_pkg

// ### core/estat_sync.sv
// three-stage pin synchroniser, change taken once stages two and three agree
`timescale 1ns/10ps
module estat_sync
	import estat_pkg::*;
#(
	parameter int N = 1
)(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [N-1:0] din,
	output logic      [N-1:0] dout
);
	logic [N-1:0] s1_q;
	logic [N-1:0] s2_q;
	logic [N-1:0] s3_q;
	logic [N-1:0] out_q;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else
		begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// bitwise agreement filters a single metastable sample
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			out_q <= '0;
		else
			out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
	end

	assign dout = out_q;
endmodule : estat_sync

// ### core/estat_cnt.sv
// saturating statistics counter, an event in the clear cycle is kept
`timescale 1ns/10ps
module estat_cnt
	import estat_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   clr,
	input  wire logic [ESTAT_INC_W-1:0] inc,
	output logic      [ESTAT_CNT_W-1:0] val
);
	logic [ESTAT_CNT_W-1:0] val_q;
	logic [ESTAT_CNT_W:0]   sum;

	always_comb
	begin
		sum = (clr ? '0 : {1'b0, val_q}) + (ESTAT_CNT_W + 1)'(inc);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			val_q <= '0;
		else if (sum[ESTAT_CNT_W])
			val_q <= '1;
		else
			val_q <= sum[ESTAT_CNT_W-1:0];
	end

	assign val = val_q;
endmodule : estat_cnt

// ### dv/estat_link_partner.sv
// link partner model: switch or hub facing the mac pins
`timescale 1ns/10ps
module estat_link_partner
(
	input  wire logic [1:0] mode,
	output logic            link_up,
	output logic            spd100,
	output logic            fdx,
	output logic            an,
	output logic            crs
);
	// ====
	// pin levels per mode
	// 0 down, 1 hub 10M half no negotiation, 2 switch 100M full, 3 switch 10M full
	assign link_up = (mode != 2'h0);
	assign spd100  = (mode == 2'h2);
	assign fdx     = mode[1];
	assign an      = mode[1];
	// carrier never echoed, so a half-duplex send sees carrier loss
	assign crs     = 1'b0;
endmodule : estat_link_partner

// ### dv/estat_top_sva.sv
// assertion checker for the ethernet statistics block
`timescale 1ns/10ps
module estat_checker
	import estat_pkg::*;
(
	input wire logic       CLK_SYS,
	input wire logic       RSTN,
	input wire logic       PSEL,
	input wire logic       PENABLE,
	input wire logic       PSLVERR,
	input wire logic       TX_COLL,
	input wire logic       TX_LAST,
	input wire logic       TX_FIFO_EMPTY,
	input wire logic       TX_GO,
	input wire logic       TX_RETRY,
	input wire logic       TX_ABANDON,
	input wire logic       TX_TRUNC,
	input wire logic       TX_DONE,
	input wire logic [1:0] SPEED_CODE,
	input wire logic [1:0] DUPLEX_CODE,
	input wire logic       DUPLEX_WARN
);
	// ====
	// properties
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	chk_err_access: assert property (PSLVERR |-> PSEL && PENABLE)
		else $error("slave error outside access phase");
	chk_retry_cause: assert property (TX_RETRY |-> $past(TX_COLL))
		else $error("retry without collision");
	chk_abandon_cause: assert property (TX_ABANDON |-> $past(TX_COLL))
		else $error("abandon without collision");
	chk_done_cause: assert property (TX_DONE |-> $past(TX_LAST) && !$past(TX_COLL))
		else $error("done without last byte");
	chk_trunc_cause: assert property (TX_TRUNC |-> $past(TX_FIFO_EMPTY) && !$past(TX_COLL))
		else $error("truncation without empty fifo");
	chk_tx_onehot: assert property ($onehot0({TX_GO, TX_RETRY, TX_ABANDON, TX_TRUNC, TX_DONE}))
		else $error("two transmit outcomes at once");
	chk_code_legal: assert property (SPEED_CODE != 2'h3 && DUPLEX_CODE != 2'h3)
		else $error("illegal status code");
	chk_unknown_pair: assert property ((SPEED_CODE == SPD_UNKNOWN) == (DUPLEX_CODE == DPX_UNKNOWN))
		else $error("speed and duplex disagree on link");
	chk_warn_link: assert property (DUPLEX_WARN |-> SPEED_CODE != SPD_UNKNOWN)
		else $error("duplex warning without link");
	cov_done: cover property (TX_DONE);
	cov_abandon: cover property (TX_ABANDON);
	cov_trunc: cover property (TX_TRUNC);
	cov_warn: cover property (DUPLEX_WARN);
endmodule : estat_checker

bind estat_top estat_checker i_estat_checker (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL),
	.PENABLE(PENABLE), .PSLVERR(PSLVERR), .TX_COLL(TX_COLL), .TX_LAST(TX_LAST),
	.TX_FIFO_EMPTY(TX_FIFO_EMPTY), .TX_GO(TX_GO), .TX_RETRY(TX_RETRY), .TX_ABANDON(TX_ABANDON),
	.TX_TRUNC(TX_TRUNC), .TX_DONE(TX_DONE), .SPEED_CODE(SPEED_CODE),
	.DUPLEX_CODE(DUPLEX_CODE), .DUPLEX_WARN(DUPLEX_WARN));

// ### dv/tb_top.sv
// self-checking testbench of the ethernet statistics block
`timescale 1ns/10ps
module tb_top
	import estat_pkg::*;
;
	typedef struct {logic [15:0] len; logic [2:0] flg; logic [3:0] pul; int idx; int d;} estat_row_t;
	logic clk = 0, rstn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic rx_end, rx_crc, rx_odd, rx_filt, rx_ovf, rx_nobuf, rx_nobuf2, rx_coll;
	logic [15:0] rx_len;
	logic tx_req, tx_backoff, tx_dma, tx_coll, tx_empty, tx_last;
	logic tx_go, tx_retry, tx_abandon, tx_trunc, tx_done, err;
	logic crs, lk_up, lk_spd, lk_fdx, lk_an, warn;
	logic [1:0] pmode, spd_code, dpx_code;
	int mismatches = 0, n_checks = 0;
	int exp_cnt [ESTAT_NCNT];
	// mode, speed, duplex, warning
	logic [6:0] lk [4] = '{{2'h0, SPD_UNKNOWN, DPX_UNKNOWN, 1'b0}, {2'h1, SPD_10M, DPX_HALF, 1'b1},
		{2'h3, SPD_10M, DPX_FULL, 1'b0}, {2'h2, SPD_100M, DPX_FULL, 1'b0}};
	estat_row_t rows [9] = '{'{16'h05EF, 3'h0, 4'h0, CI_TOO_LONG, 1},
		'{16'h05EE, 3'h0, 4'h0, CI_TOO_LONG, 0}, '{16'h0040, 3'h1, 4'h0, CI_CRC, 1},
		'{16'h0040, 3'h2, 4'h0, CI_ALIGN, 1}, '{16'h0040, 3'h4, 4'h0, CI_FILTERED, 0},
		'{16'h0000, 3'h0, 4'h1, CI_RX_OVF, 1}, '{16'h0000, 3'h0, 4'h2, CI_RX_COLL, 1},
		'{16'h0000, 3'h0, 4'h4, CI_MISSED, 1}, '{16'h0000, 3'h0, 4'h8, CI_RX_UNDERRUN, 1}};

	always #20 clk = ~clk;

	estat_top #(.EXDEF_CYC_10M(17'h0_0028), .EXDEF_CYC_100M(17'h0_0014)) i_estat_top (
		.CLK_SYS(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.RX_END(rx_end), .RX_LEN_BYTES(rx_len), .RX_CRC_ERR(rx_crc), .RX_ODD_BITS(rx_odd),
		.RX_FILTER_DROP(rx_filt), .RX_FIFO_OVF(rx_ovf), .RX_NO_BUF(rx_nobuf),
		.RX_NO_BUF2(rx_nobuf2), .RX_COLL(rx_coll), .TX_REQ(tx_req), .TX_BACKOFF(tx_backoff),
		.TX_DMA_BUSY(tx_dma), .TX_COLL(tx_coll), .TX_FIFO_EMPTY(tx_empty), .TX_LAST(tx_last),
		.TX_GO(tx_go), .TX_RETRY(tx_retry), .TX_ABANDON(tx_abandon), .TX_TRUNC(tx_trunc),
		.TX_DONE(tx_done), .TX_CRS(crs), .LINK_UP(lk_up), .LINK_SPD100(lk_spd),
		.LINK_FDX(lk_fdx), .PARTNER_AN(lk_an), .SPEED_CODE(spd_code), .DUPLEX_CODE(dpx_code),
		.DUPLEX_WARN(warn));
	estat_link_partner i_estat_link_partner (.mode(pmode), .link_up(lk_up), .spd100(lk_spd),
		.fdx(lk_fdx), .an(lk_an), .crs(crs));

	// ====
	// compare and bus tasks
	task automatic summarize;
		if (mismatches == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task automatic check_word(string n, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : check_word
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int k;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		q = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
		if (pready !== 1'b1)
		begin
			mismatches++;
			summarize();
		end
	endtask : apb
	task automatic rd_chk(string n, logic [7:0] a, int e);
		apb(1'b0, a, 32'h0000_0000);
		check_word(n, 32'(e), q);
	endtask : rd_chk
	task automatic sweep;
		for (int i = 0; i < ESTAT_NCNT; i++)
			rd_chk("counter", 8'(4 * i), exp_cnt[i]);
	endtask : sweep
	task automatic rx_ev(estat_row_t r);
		@(posedge clk);
		{rx_end, rx_len} <= {r.len != 16'h0000, r.len};
		{rx_filt, rx_odd, rx_crc, rx_nobuf2, rx_nobuf, rx_coll, rx_ovf} <= {r.flg, r.pul};
		@(posedge clk);
		{rx_end, rx_filt, rx_odd, rx_crc, rx_nobuf2, rx_nobuf, rx_coll, rx_ovf} <= 8'h00;
	endtask : rx_ev
	task automatic wait_go;
		int k;
		k = 0;
		do
		begin
			@(negedge clk);
			k++;
		end
		while (tx_go !== 1'b1 && k < 300);
		if (tx_go !== 1'b1)
		begin
			mismatches++;
			summarize();
		end
	endtask : wait_go
	// fin 0 ends with last byte, 1 with empty fifo, 2 when the final collision abandons
	task automatic tx_frame(int nc, int gap, int fin);
		logic ab;
		@(posedge clk);
		tx_req <= 1'b1;
		for (int c = 0; c < nc; c++)
		begin
			ab = (fin == 2 && c == nc - 1);
			wait_go();
			repeat (gap) @(posedge clk);
			{tx_coll, tx_req} <= {1'b1, !ab};
			@(posedge clk);
			tx_coll <= 1'b0;
			@(negedge clk);
			check_word("tx retry/abandon", {30'h0, !ab, ab}, {30'h0, tx_retry, tx_abandon});
		end
		if (fin == 2)
			return;
		wait_go();
		repeat (gap) @(posedge clk);
		{tx_last, tx_empty, tx_req} <= {fin == 0, fin == 1, 1'b0};
		@(posedge clk);
		{tx_last, tx_empty} <= 2'b00;
		@(negedge clk);
		check_word("tx done/trunc", {30'h0, fin == 0, fin == 1}, {30'h0, tx_done, tx_trunc});
	endtask : tx_frame

	// ====
	// main sequence
	initial
	begin
		{rstn, psel, penable, pwrite, paddr, pwdata, rx_len} = '0;
		{rx_end, rx_crc, rx_odd, rx_filt, rx_ovf, rx_nobuf, rx_nobuf2, rx_coll} = '0;
		{tx_req, tx_backoff, tx_dma, tx_coll, tx_empty, tx_last, pmode} = '0;
		foreach (exp_cnt[i]) exp_cnt[i] = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		foreach (lk[i])
		begin
			@(posedge clk);
			pmode <= lk[i][6:5];
			repeat (8) @(posedge clk);
			@(negedge clk);
			check_word("link codes", 32'(lk[i][4:0]), 32'({spd_code, dpx_code, warn}));
		end
		foreach (rows[i])
		begin
			rx_ev(rows[i]);
			exp_cnt[rows[i].idx] += rows[i].d;
			rd_chk("rx counter", 8'(4 * rows[i].idx), exp_cnt[rows[i].idx]);
		end
		apb(1'b1, OFF_CTRL, 32'h0000_0001);
		rx_ev(rows[4]);
		rx_ev(rows[4]);
		rd_chk("filtered", 8'(4 * CI_FILTERED), 2);
		rd_chk("filtered reread", 8'(4 * CI_FILTERED), 0);
		tx_frame(0, 3, 0);
		tx_frame(1, 3, 0);
		tx_frame(2, 3, 0);
		tx_frame(16, 3, 2);
		tx_frame(1, 130, 2);
		tx_frame(0, 3, 1);
		@(posedge clk);
		{tx_dma, tx_backoff} <= 2'b11;
		fork
			tx_frame(0, 2, 0);
			begin
				// backoff first, then dma busy alone past the deferral limit
				repeat (8) @(posedge clk);
				tx_backoff <= 1'b0;
				repeat (30) @(posedge clk);
				tx_dma <= 1'b0;
			end
		join
		// half duplex, carrier never echoed: every send loses carrier
		@(posedge clk);
		pmode <= 2'h1;
		repeat (8) @(posedge clk);
		tx_frame(0, 3, 0);
		tx_frame(1, 3, 2);
		exp_cnt[CI_ONE_RETRY]    = 1;
		exp_cnt[CI_SINGLE_COLL]  = 1;
		exp_cnt[CI_MULTI_COLL]   = 1;
		exp_cnt[CI_MULTI_RETRY]  = 1;
		exp_cnt[CI_EXCESS_COLL]  = 1;
		exp_cnt[CI_LATE_COLL]    = 1;
		exp_cnt[CI_TX_UNDERFLOW] = 1;
		exp_cnt[CI_TOTAL_COLL]   = 21;
		exp_cnt[CI_LOST_CARRIER] = 2;
		exp_cnt[CI_DEFERRED]     = 1;
		exp_cnt[CI_EXCESS_DEFER] = 1;
		apb(1'b1, 8'h00, 32'h0000_00AA);
		sweep();
		apb(1'b0, 8'h60, 32'h0000_0000);
		check_word("unmapped", 32'h0000_0001, {q[30:0], err});
		apb(1'b1, OFF_CTRL, 32'h0000_0003);
		foreach (exp_cnt[i]) if (i != CI_RX_COLL && i != CI_MISSED) exp_cnt[i] = 0;
		rd_chk("ctrl", OFF_CTRL, 1);
		sweep();
		@(posedge clk);
		rx_coll <= 1'b1;
		repeat (65540) @(posedge clk);
		rx_coll <= 1'b0;
		rd_chk("saturated", 8'(4 * CI_RX_COLL), 16'hFFFF);
		apb(1'b1, OFF_CTRL, 32'h0000_0005);
		foreach (exp_cnt[i]) exp_cnt[i] = 0;
		sweep();
		// mid-run reset: read data, link codes and strobes drop at once
		rd_chk("ctrl", OFF_CTRL, 1);
		rstn <= 1'b0;
		@(negedge clk);
		check_word("reset outputs", 32'h0, 32'({prdata[0], spd_code, dpx_code, warn, tx_go}));
		@(posedge clk);
		rstn <= 1'b1;
		rd_chk("ctrl after reset", OFF_CTRL, 0);
		summarize();
	end
endmodule : tb_top
